// ### hw/evd_dispatch.sv
// evd_dispatch: exception sequencing, vector address generation, state save
// assumes memory answers each request with one-cycle MEM_ACK, level inputs
`timescale 1ns/10ps
`default_nettype none
module evd_dispatch
	import evd_pkg::*;
(
	// clock and reset
	input  wire logic                MCLK,
	input  wire logic                SYS_RST,
	input  wire logic                CLK_EN,
	// reset pins, watchdog
	input  wire logic                POWER_ON_RESET_PIN,
	input  wire logic                MANUAL_RESET_PIN,
	input  wire logic                WATCHDOG_OVERFLOW_SOURCE,
	// address errors and interrupts
	input  wire logic                CPU_ADDR_ERR,
	input  wire logic                XFER_ADDR_ERR,
	input  wire logic                INT_REQ,
	input  wire logic [7:0]          INT_VEC,
	input  wire logic [3:0]          INT_LEVEL,
	// decoder
	input  wire evd_pkg::evd_dec_s   DEC,
	// core state
	input  wire logic [31:0]         STATUS_WORD_IN,
	input  wire logic [31:0]         STACK_POINTER_GPR_IN,
	input  wire logic [31:0]         PC_IN,
	// memory port
	output evd_pkg::evd_mreq_s       MEM,
	input  wire logic                MEM_ACK,
	input  wire logic [31:0]         MEM_RDATA,
	// core updates
	output logic                     BUSY,
	output logic                     PC_LOAD,
	output logic [31:0]              PC_OUT,
	output logic                     SP_LOAD,
	output logic [31:0]              SP_OUT,
	output logic                     SR_LOAD,
	output logic [31:0]              SR_OUT,
	output logic [31:0]              VECTOR_BASE_REGISTER,
	input  wire logic                VBR_LOAD_IN,
	input  wire logic [31:0]         VBR_WDATA,
	output logic                     TAKEN,
	output logic [7:0]               TAKEN_VEC
);

	evd_state_e  state_r, state_nxt;
	logic [2:0]  pon_sy_r, man_sy_r;
	logic        pon_lvl_r, man_lvl_r;
	logic        pon_pend_r, man_pend_r, manual_r;
	logic [7:0]  vec_r;
	logic        is_int_r;
	logic [3:0]  lvl_r;
	logic [31:0] sp_r, sr_r, pc_r, vbr_r;
	evd_mreq_s   mem_r;
	logic        pc_load_r, sp_load_r, sr_load_r, taken_r;
	logic [31:0] pc_out_r, sp_out_r, sr_out_r;

	// three-stage sync; a change counts once stages two and three agree
	wire pon_agree = pon_sy_r[1] == pon_sy_r[2];
	wire man_agree = man_sy_r[1] == man_sy_r[2];
	wire pon_rise  = pon_agree && pon_sy_r[2] && !pon_lvl_r;
	wire man_rise  = man_agree && man_sy_r[2] && !man_lvl_r;
	wire pon_evt   = pon_rise || WATCHDOG_OVERFLOW_SOURCE;

	// non-reset sources, fixed priority
	wire aerr_any  = CPU_ADDR_ERR || XFER_ADDR_ERR;
	wire gen_ill   = DEC.undef_op && !DEC.in_slot;
	wire slot_ill  = DEC.in_slot && (DEC.undef_op || DEC.pc_write_op);
	wire boundary  = DEC.boundary;
	wire take_aerr = boundary && aerr_any;
	wire take_int  = boundary && !aerr_any && INT_REQ;
	wire trap_go   = DEC.trap_exec;
	wire take_ins  = !take_aerr && !take_int && (trap_go || gen_ill || slot_ill);
	wire take_any  = take_aerr || take_int || take_ins;

	// trap immediates folded into the user range; out-of-range values wrap
	wire [7:0] trap_vec = VEC_TRAP_LO | {3'b000, DEC.trap_imm[4:0]};
	wire [7:0] aerr_vec = CPU_ADDR_ERR ? VEC_CPU_AERR : VEC_XFER_AERR;
	// reserved irq slots are not screened out; irq vector passes as given
	wire [7:0] int_vec  = INT_VEC;
	wire [7:0] ins_vec  = slot_ill ? VEC_SLOT_ILL
		: (gen_ill ? VEC_GEN_ILL : trap_vec);
	wire [7:0] sel_vec  = take_aerr ? aerr_vec : (take_int ? int_vec : ins_vec);

	wire [31:0] vec_off    = {22'h0, vec_r, 2'b00};
	wire [31:0] handler_a  = vbr_r + vec_off;
	// launch edge picks the slot pair before manual_r itself is written
	wire        rst_launch = state_nxt == ST_RFETCH && state_r != ST_RFETCH;
	wire        man_sel    = rst_launch ? !(pon_pend_r || pon_evt) : manual_r;
	wire [31:0] rst_pc_a   = {22'h0, man_sel ? VEC_MAN_PC : VEC_PON_PC, 2'b00};
	wire [31:0] rst_sp_a   = {22'h0, man_sel ? VEC_MAN_SP : VEC_PON_SP, 2'b00};
	wire [31:0] sp_dec     = sp_r - SP_STEP;
	// sp_r has stepped once while the pc push waits; the address must not move
	wire [31:0] pc_push_a  = state_r == ST_PUSHPC ? sp_dec : sp_dec - SP_STEP;
	wire [31:0] sr_masked  = {sr_r[31:MASK_LSB+4], lvl_r, sr_r[MASK_LSB-1:0]};

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:   if (take_any) state_nxt = ST_PUSHSR;
			ST_RFETCH: if (MEM_ACK) state_nxt = ST_RSP;
			ST_RSP:    if (MEM_ACK) state_nxt = ST_RDONE;
			ST_RDONE:  state_nxt = ST_IDLE;
			ST_PUSHSR: if (MEM_ACK) state_nxt = ST_PUSHPC;
			ST_PUSHPC: if (MEM_ACK) state_nxt = ST_VFETCH;
			ST_VFETCH: if (MEM_ACK) state_nxt = ST_DONE;
			ST_DONE:   state_nxt = ST_IDLE;
			default:   state_nxt = ST_IDLE;
		endcase
		if (pon_pend_r || man_pend_r || pon_evt || man_rise)
		begin
			if (state_r == ST_IDLE || state_r == ST_DONE || state_r == ST_RDONE)
				state_nxt = ST_RFETCH;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			state_r    <= ST_IDLE;
			pon_sy_r   <= 3'b000;
			man_sy_r   <= 3'b000;
			pon_lvl_r  <= 1'b0;
			man_lvl_r  <= 1'b0;
			pon_pend_r <= 1'b0;
			man_pend_r <= 1'b0;
			manual_r   <= 1'b0;
			vec_r      <= 8'h00;
			is_int_r   <= 1'b0;
			lvl_r      <= 4'h0;
			sp_r       <= 32'h0;
			sr_r       <= 32'h0;
			pc_r       <= 32'h0;
			vbr_r      <= VBR_RESET;
		end
		else if (CLK_EN)
		begin
			state_r  <= state_nxt;
			pon_sy_r <= {pon_sy_r[1:0], POWER_ON_RESET_PIN};
			man_sy_r <= {man_sy_r[1:0], MANUAL_RESET_PIN};
			if (pon_agree)
				pon_lvl_r <= pon_sy_r[2];
			if (man_agree)
				man_lvl_r <= man_sy_r[2];
			// pending reset held until the reset sequence launches
			if (state_nxt == ST_RFETCH && state_r != ST_RFETCH)
			begin
				manual_r   <= !(pon_pend_r || pon_evt);
				pon_pend_r <= 1'b0;
				man_pend_r <= 1'b0;
			end
			else
			begin
				pon_pend_r <= pon_pend_r || pon_evt;
				man_pend_r <= man_pend_r || man_rise;
			end
			if (state_r == ST_IDLE && take_any && state_nxt == ST_PUSHSR)
			begin
				vec_r    <= sel_vec;
				is_int_r <= take_int;
				lvl_r    <= take_int ? INT_LEVEL : STATUS_WORD_IN[MASK_LSB+3:MASK_LSB];
				sp_r     <= STACK_POINTER_GPR_IN;
				sr_r     <= STATUS_WORD_IN;
				pc_r     <= PC_IN;
			end
			if (MEM_ACK && (state_r == ST_PUSHSR || state_r == ST_PUSHPC))
				sp_r <= sp_dec;
			if (state_r == ST_RFETCH && MEM_ACK)
				vbr_r <= VBR_RESET;
			else if (VBR_LOAD_IN && state_r == ST_IDLE)
				vbr_r <= VBR_WDATA;
		end
	end

	// memory request and core-update outputs, registered
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			mem_r     <= '0;
			pc_load_r <= 1'b0;
			sp_load_r <= 1'b0;
			sr_load_r <= 1'b0;
			taken_r   <= 1'b0;
			pc_out_r  <= 32'h0;
			sp_out_r  <= 32'h0;
			sr_out_r  <= 32'h0;
		end
		else if (CLK_EN)
		begin
			pc_load_r <= 1'b0;
			sp_load_r <= 1'b0;
			sr_load_r <= 1'b0;
			taken_r   <= state_r == ST_IDLE && state_nxt == ST_PUSHSR;
			mem_r.req <= 1'b0;
			mem_r.wr  <= 1'b0;
			unique case (state_nxt)
				ST_RFETCH:
				begin
					mem_r.req  <= 1'b1;
					mem_r.addr <= rst_pc_a;
				end
				ST_RSP:
				begin
					mem_r.req  <= 1'b1;
					mem_r.addr <= rst_sp_a;
				end
				ST_PUSHSR:
				begin
					mem_r.req   <= 1'b1;
					mem_r.wr    <= 1'b1;
					mem_r.addr  <= (state_r == ST_IDLE ? STACK_POINTER_GPR_IN : sp_r) - SP_STEP;
					mem_r.wdata <= state_r == ST_IDLE ? STATUS_WORD_IN : sr_r;
				end
				ST_PUSHPC:
				begin
					mem_r.req   <= 1'b1;
					mem_r.wr    <= 1'b1;
					mem_r.addr  <= pc_push_a;
					mem_r.wdata <= pc_r;
				end
				ST_VFETCH:
				begin
					mem_r.req  <= 1'b1;
					mem_r.addr <= handler_a;
				end
				default:
				begin
					mem_r.req <= 1'b0;
				end
			endcase
			if (state_r == ST_RFETCH && MEM_ACK)
			begin
				pc_load_r <= 1'b1;
				pc_out_r  <= MEM_RDATA;
				sr_load_r <= 1'b1;
				sr_out_r  <= {STATUS_WORD_IN[31:MASK_LSB+4], MASK_RESET,
					STATUS_WORD_IN[MASK_LSB-1:0]};
			end
			if (state_r == ST_RSP && MEM_ACK)
			begin
				sp_load_r <= 1'b1;
				sp_out_r  <= MEM_RDATA;
			end
			if (state_r == ST_PUSHPC && MEM_ACK)
			begin
				sp_load_r <= 1'b1;
				sp_out_r  <= sp_dec;
				sr_load_r <= 1'b1;
				// of the stacked exceptions only interrupts rewrite the mask; lvl_r holds the old mask otherwise
				sr_out_r  <= is_int_r ? sr_masked : sr_r;
			end
			if (state_r == ST_VFETCH && MEM_ACK)
			begin
				pc_load_r <= 1'b1;
				pc_out_r  <= MEM_RDATA;
			end
		end
	end

	assign MEM                  = mem_r;
	assign BUSY                 = state_r != ST_IDLE;
	assign PC_LOAD              = pc_load_r;
	assign PC_OUT               = pc_out_r;
	assign SP_LOAD              = sp_load_r;
	assign SP_OUT               = sp_out_r;
	assign SR_LOAD              = sr_load_r;
	assign SR_OUT               = sr_out_r;
	assign VECTOR_BASE_REGISTER = vbr_r;
	assign TAKEN                = taken_r;
	assign TAKEN_VEC            = vec_r;

	slot_vec_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && state_r == ST_IDLE && take_ins && slot_ill && state_nxt == ST_PUSHSR)
		|=> vec_r == VEC_SLOT_ILL)
		else $error("slot illegal vector wrong");
	reset_base_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && state_r == ST_RFETCH && MEM_ACK) |=> vbr_r == 32'h0 && SR_OUT[7:4] == 4'hf)
		else $error("reset did not clear base or set mask");
	push_order_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && state_r == ST_PUSHSR && MEM_ACK) |=> state_r == ST_PUSHPC)
		else $error("status not pushed before pc");
	handler_addr_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(state_r == ST_VFETCH && MEM.req) |-> MEM.addr == vbr_r + {22'h0, vec_r, 2'b00})
		else $error("handler address wrong");
	reset_vec_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(state_r == ST_RFETCH && MEM.req) |-> MEM.addr == (manual_r ? 32'h8 : 32'h0))
		else $error("reset pc slot wrong");
	mask_keep_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && state_r == ST_PUSHPC && MEM_ACK && !is_int_r) |=> SR_OUT == sr_r)
		else $error("mask changed on non-interrupt");
	aerr_first_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && state_r == ST_IDLE && boundary && aerr_any && state_nxt == ST_PUSHSR)
		|=> vec_r == $past(aerr_vec))
		else $error("address error lost priority");
	gen_vec_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && state_r == ST_IDLE && take_ins && gen_ill && !slot_ill
		&& state_nxt == ST_PUSHSR) |=> vec_r == VEC_GEN_ILL)
		else $error("general illegal vector wrong");
	pc_push_addr_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(state_r == ST_PUSHPC && MEM.req) |-> MEM.addr == sp_dec)
		else $error("pc push address moved");
	req_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && MEM.req && !MEM_ACK) |=> MEM.req && $stable(MEM.addr)
		&& $stable(MEM.wdata) && $stable(MEM.wr))
		else $error("memory request dropped before ack");
	int_mask_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && state_r == ST_PUSHPC && MEM_ACK && is_int_r)
		|=> SR_LOAD && SR_OUT[MASK_LSB+:4] == lvl_r)
		else $error("interrupt level not loaded into mask");
	trap_range_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && state_r == ST_IDLE && take_ins && trap_go && !gen_ill && !slot_ill
		&& state_nxt == ST_PUSHSR) |=> vec_r >= VEC_TRAP_LO && vec_r <= VEC_TRAP_HI)
		else $error("trap vector outside user range");
	handler_jump_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CLK_EN && state_r == ST_VFETCH && MEM_ACK) |=> PC_LOAD && PC_OUT == $past(MEM_RDATA))
		else $error("handler address not loaded");

endmodule
`default_nettype wire

// ### hw/evd_pkg.sv
// evd_pkg: constants, states and carriers for the exception dispatch unit
// assumes a 32-bit core with a 32-bit longword memory port
package evd_pkg;

	// vector numbers
	localparam logic [7:0] VEC_PON_PC    = 8'h00;
	localparam logic [7:0] VEC_PON_SP    = 8'h01;
	localparam logic [7:0] VEC_MAN_PC    = 8'h02;
	localparam logic [7:0] VEC_MAN_SP    = 8'h03;
	localparam logic [7:0] VEC_GEN_ILL   = 8'h04;
	localparam logic [7:0] VEC_SLOT_ILL  = 8'h06;
	localparam logic [7:0] VEC_CPU_AERR  = 8'h09;
	localparam logic [7:0] VEC_XFER_AERR = 8'h0a;
	localparam logic [7:0] VEC_NMI       = 8'h0b;
	localparam logic [7:0] VEC_UBRK      = 8'h0c;
	localparam logic [7:0] VEC_TRAP_LO   = 8'h20;
	localparam logic [7:0] VEC_TRAP_HI   = 8'h3f;
	localparam logic [7:0] VEC_IRQ_BASE  = 8'h40;
	localparam logic [7:0] VEC_RSV_LO    = 8'h44;
	localparam logic [7:0] VEC_RSV_HI    = 8'h47;
	localparam logic [7:0] VEC_PERI_LO   = 8'h48;
	localparam logic [7:0] VEC_PERI_HI   = 8'hff;

	// status word layout and reset values
	localparam int         MASK_LSB      = 4;
	localparam logic [3:0] MASK_RESET    = 4'hf;
	localparam logic [31:0] VBR_RESET    = 32'h0000_0000;
	localparam logic [31:0] SP_STEP      = 32'h0000_0004;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_RFETCH = 4'b0001,
		ST_RSP    = 4'b0010,
		ST_RDONE  = 4'b0011,
		ST_PUSHSR = 4'b0100,
		ST_PUSHPC = 4'b0101,
		ST_VFETCH = 4'b0110,
		ST_DONE   = 4'b0111
	} evd_state_e;

	// memory request carrier
	typedef struct packed {
		logic        req;
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
	} evd_mreq_s;

	// instruction-side event carrier
	typedef struct packed {
		logic       boundary;
		logic       undef_op;
		logic       pc_write_op;
		logic       in_slot;
		logic       trap_exec;
		logic [7:0] trap_imm;
	} evd_dec_s;

endpackage

// ### tb/evd_mem_model.sv
// evd_mem_model: longword memory on the far side of the dispatch unit
// assumes one request held until acked; ack is one cycle, delay is set by the bench
`timescale 1ns/10ps
`default_nettype none
module evd_mem_model
	import evd_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// request side
	input  wire evd_pkg::evd_mreq_s mreq,
	input  wire logic [3:0]         wait_cycles,
	// answer side
	output logic                    ack,
	output logic [31:0]             rdata
);
	logic [31:0] store [logic [31:0]];
	logic [64:0] log_q [$];
	logic [3:0]  wait_r;
	// unwritten words hold a pattern of their address, so every slot is distinct
	function automatic logic [31:0] word_at(input logic [31:0] a);
		return store.exists(a) ? store[a] : (a ^ 32'h5a5a_0000);
	endfunction
	always @(posedge clk)
	begin
		// read data toggles outside the ack cycle; a stale word must never look valid
		rdata <= ~rdata;
		ack <= 1'b0;
		if (rst)
			wait_r <= 4'h0;
		else if (ack || !mreq.req)
			wait_r <= 4'h0;
		else if (wait_r < wait_cycles)
			wait_r <= wait_r + 4'h1;
		else
		begin
			ack <= 1'b1;
			log_q.push_back({mreq.wr, mreq.addr, mreq.wdata});
			rdata <= word_at(mreq.addr);
			if (mreq.wr)
				store[mreq.addr] = mreq.wdata;
		end
	end
endmodule
`default_nettype wire

// ### tb/tb_evd_dispatch.sv
// tb_evd_dispatch: directed scenarios for the exception dispatch unit
// assumes the memory model of evd_mem_model on the memory port
`timescale 1ns/10ps
`default_nettype none
module tb_evd_dispatch;
	import evd_pkg::*;
	localparam logic [31:0] SP_V = 32'h0000_8000;
	localparam logic [31:0] SR_V = 32'h0000_00a3;
	localparam logic [31:0] PC_V = 32'h0000_1234;
	localparam logic [31:0] VB_V = 32'h0000_2000;
	logic        mclk = 1'b0, sys_rst = 1'b1, pon = 1'b0, man = 1'b0, wdt = 1'b0;
	logic        cerr = 1'b0, xerr = 1'b0, ireq = 1'b0, ack, busy, pcl, spl, srl, tk;
	logic        vld = 1'b0;
	logic [7:0]  ivec = 8'h00, tvec, tv_got;
	logic [3:0]  ilvl = 4'h0, lat = 4'h0;
	logic [31:0] rdata, pco, spo, sro, vector_base_register, pc_got, sp_got, sr_got;
	evd_dec_s    dec = '0;
	evd_mreq_s   mreq;
	int          mismatches = 0, tests_run = 0, cyc = 0, taken_n = 0;
	always #25 mclk = ~mclk;
	evd_dispatch dut (.MCLK(mclk), .SYS_RST(sys_rst), .CLK_EN(1'b1),
		.POWER_ON_RESET_PIN(pon), .MANUAL_RESET_PIN(man), .WATCHDOG_OVERFLOW_SOURCE(wdt),
		.CPU_ADDR_ERR(cerr), .XFER_ADDR_ERR(xerr), .INT_REQ(ireq), .INT_VEC(ivec),
		.INT_LEVEL(ilvl), .DEC(dec), .STATUS_WORD_IN(SR_V), .STACK_POINTER_GPR_IN(SP_V),
		.PC_IN(PC_V), .MEM(mreq), .MEM_ACK(ack), .MEM_RDATA(rdata), .BUSY(busy),
		.PC_LOAD(pcl), .PC_OUT(pco), .SP_LOAD(spl), .SP_OUT(spo), .SR_LOAD(srl),
		.SR_OUT(sro), .VECTOR_BASE_REGISTER(vector_base_register), .VBR_LOAD_IN(vld),
		.VBR_WDATA(VB_V), .TAKEN(tk), .TAKEN_VEC(tvec));
	evd_mem_model mdl (.clk(mclk), .rst(sys_rst), .mreq(mreq), .wait_cycles(lat),
		.ack(ack), .rdata(rdata));
	always @(posedge mclk)
	begin
		if (pcl === 1'b1) pc_got <= pco;
		if (spl === 1'b1) sp_got <= spo;
		if (srl === 1'b1) sr_got <= sro;
		if (tk === 1'b1) tv_got <= tvec;
		if (tk === 1'b1) taken_n <= taken_n + 1;
		cyc <= cyc + 1;
		// whole run is well under a thousand cycles
		if (cyc == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic clear();
		mdl.log_q.delete();
		{pc_got, sp_got, sr_got, tv_got} = 'x;
	endtask
	task automatic wait_done();
		int n;
		repeat (8) @(posedge mclk);
		for (n = 0; n < 300 && busy !== 1'b0; n++) @(posedge mclk);
		#1;
		chk({31'h0, busy}, 32'h0);
	endtask
	// one logged memory access: direction, address and, for writes, data
	task automatic chk_acc(input int i, input logic wr, input logic [31:0] a, d);
		logic [64:0] e;
		e = mdl.log_q[i];
		chk({31'h0, e[64]}, {31'h0, wr});
		chk(e[63:32], a);
		if (wr) chk(e[31:0], d);
	endtask
	// sel 0: power-on pin rise, 1: manual pin rise, 2: watchdog pulse
	task automatic rst_case(input int sel);
		logic [31:0] a;
		a = (sel == 1) ? 32'h8 : 32'h0;
		clear();
		@(posedge mclk);
		if (sel == 0) pon <= 1'b1;
		if (sel == 1) man <= 1'b1;
		if (sel == 2) wdt <= 1'b1;
		@(posedge mclk);
		wdt <= 1'b0;
		wait_done();
		chk(32'(mdl.log_q.size()), 32'h2);
		chk_acc(0, 1'b0, a, 32'h0);
		chk_acc(1, 1'b0, a + 32'h4, 32'h0);
		chk(pc_got, a ^ 32'h5a5a_0000);
		chk(sp_got, (a + 32'h4) ^ 32'h5a5a_0000);
		chk({28'h0, sr_got[MASK_LSB+:4]}, 32'hf);
		chk(vector_base_register, 32'h0);
	endtask
	// src bits: cpu address error, transfer address error, interrupt request
	task automatic exc_case(input logic [12:0] d, input logic [2:0] src, input logic [7:0] iv,
		input logic [3:0] il, input logic [7:0] ev, input logic [3:0] em);
		logic [31:0] va, sr_e;
		va = {22'h0, ev, 2'b00};
		sr_e = SR_V;
		sr_e[MASK_LSB+:4] = em;
		clear();
		@(posedge mclk);
		dec <= evd_dec_s'(d);
		{cerr, xerr, ireq} <= src;
		{ivec, ilvl} <= {iv, il};
		@(posedge mclk);
		dec <= '0;
		{cerr, xerr, ireq} <= 3'b000;
		wait_done();
		chk({24'h0, tv_got}, {24'h0, ev});
		chk(32'(mdl.log_q.size()), 32'h3);
		chk_acc(0, 1'b1, SP_V - 32'h4, SR_V);
		chk_acc(1, 1'b1, SP_V - 32'h8, PC_V);
		chk_acc(2, 1'b0, VB_V + va, 32'h0);
		chk(pc_got, (VB_V + va) ^ 32'h5a5a_0000);
		chk(sp_got, SP_V - 32'h8);
		chk(sr_got, sr_e);
	endtask
	// nonzero base, so a reset visibly clears it and handler fetches add it
	task automatic base_case();
		@(posedge mclk);
		vld <= 1'b1;
		@(posedge mclk);
		vld <= 1'b0;
		@(posedge mclk);
		chk(vector_base_register, VB_V);
	endtask
	// an interrupt away from an instruction boundary must not start anything
	task automatic no_boundary_case();
		int n0;
		n0 = taken_n;
		@(posedge mclk);
		ireq <= 1'b1;
		repeat (4) @(posedge mclk);
		ireq <= 1'b0;
		repeat (4) @(posedge mclk);
		chk(32'(taken_n - n0), 32'h0);
		chk({31'h0, busy}, 32'h0);
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge mclk);
		base_case();
		rst_case(0);
		rst_case(1);
		rst_case(2);
		no_boundary_case();
		base_case();
		exc_case({5'b00001, 8'h05}, 3'b000, 8'h00, 4'h0, 8'h25, 4'ha);
		lat <= 4'h3;
		exc_case({5'b00001, 8'h1f}, 3'b000, 8'h00, 4'h0, 8'h3f, 4'ha);
		lat <= 4'h0;
		exc_case({5'b01000, 8'h00}, 3'b000, 8'h00, 4'h0, VEC_GEN_ILL, 4'ha);
		exc_case({5'b01010, 8'h00}, 3'b000, 8'h00, 4'h0, VEC_SLOT_ILL, 4'ha);
		exc_case({5'b00110, 8'h00}, 3'b000, 8'h00, 4'h0, VEC_SLOT_ILL, 4'ha);
		exc_case({5'b10000, 8'h00}, 3'b100, 8'h00, 4'h0, 8'h09, 4'ha);
		exc_case({5'b10000, 8'h00}, 3'b010, 8'h00, 4'h0, 8'h0a, 4'ha);
		exc_case({5'b10000, 8'h00}, 3'b001, 8'h0b, 4'hf, 8'h0b, 4'hf);
		exc_case({5'b10000, 8'h00}, 3'b001, 8'h40, 4'h3, 8'h40, 4'h3);
		exc_case({5'b10000, 8'h00}, 3'b001, 8'hff, 4'h0, 8'hff, 4'h0);
		exc_case({5'b10001, 8'h07}, 3'b011, 8'h48, 4'h5, 8'h0a, 4'ha);
		exc_case({5'b10001, 8'h07}, 3'b001, 8'h48, 4'h5, 8'h48, 4'h5);
		give_verdict();
	end
endmodule
`default_nettype wire
